// file: rtl/cbu_params.svh
// constants of the conditional branch unit: widths, flag positions, offsets
// assumes inclusion by the package, the modules of this block, its checker and its bench
`ifndef CBU_PARAMS_SVH
`define CBU_PARAMS_SVH

// datapath widths
`define CBU_PC_W        12
`define CBU_OFS_W       7
`define CBU_FLG_W       8
`define CBU_COND_W      4
`define CBU_ADDR_W      12

// status flag positions inside the flag register
`define CBU_FLG_C       0
`define CBU_FLG_Z       1
`define CBU_FLG_N       2
`define CBU_FLG_V       3
`define CBU_FLG_S       4
`define CBU_FLG_H       5
`define CBU_FLG_T       6
`define CBU_FLG_I       7

// instruction register field layout
`define CBU_INS_COND_LO 0
`define CBU_INS_COND_HI 3
`define CBU_INS_OFS_LO  4
`define CBU_INS_OFS_HI  10

// status register bit positions
`define CBU_ST_BUSY     0
`define CBU_ST_TAKEN    1
`define CBU_ST_DONE     2
`define CBU_ST_CYC_LO   4
`define CBU_ST_CYC_HI   5

// register byte offsets
`define CBU_OFF_INSTR   12'h000
`define CBU_OFF_PC      12'h004
`define CBU_OFF_FLAGS   12'h008
`define CBU_OFF_STATUS  12'h00c

// reset values and cycle counts
`define CBU_RST_PC      12'h000
`define CBU_RST_FLAGS   8'h00
`define CBU_CYC_FALL    2'h1
`define CBU_CYC_TAKEN   2'h2

`endif

// file: rtl/cbu_pkg.sv
// types shared by the conditional branch unit
// assumes the constants header is on the include path
`include "cbu_params.svh"

package cbu_pkg;

  // condition selected by the instruction; aliases decode alike
  typedef enum logic [`CBU_COND_W-1:0] {
    CBU_CARRY_CLEAR     = 4'h0,
    CBU_CARRY_SET       = 4'h1,
    CBU_SAME_OR_HIGHER  = 4'h2,
    CBU_LOWER_UNSIGNED  = 4'h3,
    CBU_NEGATIVE        = 4'h4,
    CBU_POSITIVE        = 4'h5,
    CBU_SIGNED_GE       = 4'h6,
    CBU_SIGNED_LT       = 4'h7,
    CBU_HALF_CARRY_SET  = 4'h8,
    CBU_HALF_CARRY_CLR  = 4'h9,
    CBU_TRANSFER_SET    = 4'ha,
    CBU_TRANSFER_CLEAR  = 4'hb,
    CBU_OVERFLOW_SET    = 4'hc,
    CBU_OVERFLOW_CLEAR  = 4'hd,
    CBU_IRQ_ENABLED     = 4'he,
    CBU_IRQ_DISABLED    = 4'hf
  } cbu_cond_t;

  // sequencer states, one-hot
  typedef enum logic [2:0] {
    CBU_ST_IDLE = 3'b001,
    CBU_ST_EVAL = 3'b010,
    CBU_ST_JUMP = 3'b100
  } cbu_state_t;

endpackage

// file: rtl/cbu_cond_eval.sv
// condition test of the branch unit: picks a flag or flag pair per condition
// assumes flags are stable for the evaluation cycle; purely combinational
`timescale 1ns/10ps
`include "cbu_params.svh"

module cbu_cond_eval
  import cbu_pkg::*;
(
  // condition and flags
  input  wire cbu_pkg::cbu_cond_t     cond,
  input  wire logic [`CBU_FLG_W-1:0]  flags,
  // result
  output logic                        cond_true
);

  // single flags pulled out by position
  wire c_f = flags[`CBU_FLG_C];
  wire n_f = flags[`CBU_FLG_N];
  wire v_f = flags[`CBU_FLG_V];
  wire h_f = flags[`CBU_FLG_H];
  wire t_f = flags[`CBU_FLG_T];
  wire i_f = flags[`CBU_FLG_I];
  // signed comparison term
  wire nv_f = n_f ^ v_f;

  // condition mux
  always_comb
  begin
    case (cond)
      CBU_CARRY_CLEAR:    cond_true = ~c_f;
      CBU_CARRY_SET:      cond_true = c_f;
      CBU_SAME_OR_HIGHER: cond_true = ~c_f;
      CBU_LOWER_UNSIGNED: cond_true = c_f;
      CBU_NEGATIVE:       cond_true = n_f;
      CBU_POSITIVE:       cond_true = ~n_f;
      CBU_SIGNED_GE:      cond_true = ~nv_f;
      CBU_SIGNED_LT:      cond_true = nv_f;
      CBU_HALF_CARRY_SET: cond_true = h_f;
      CBU_HALF_CARRY_CLR: cond_true = ~h_f;
      CBU_TRANSFER_SET:   cond_true = t_f;
      CBU_TRANSFER_CLEAR: cond_true = ~t_f;
      CBU_OVERFLOW_SET:   cond_true = v_f;
      CBU_OVERFLOW_CLEAR: cond_true = ~v_f;
      CBU_IRQ_ENABLED:    cond_true = i_f;
      CBU_IRQ_DISABLED:   cond_true = ~i_f;
      default:            cond_true = 1'b0;
    endcase
  end

endmodule

// file: rtl/cbu_target_add.sv
// branch target adder: pc plus sign-extended offset plus one
// assumes the counter wraps modulo its width
`timescale 1ns/10ps
`include "cbu_params.svh"

module cbu_target_add
(
  // operands
  input  wire logic [`CBU_PC_W-1:0]  pc,
  input  wire logic [`CBU_OFS_W-1:0] ofs,
  // results
  output logic      [`CBU_PC_W-1:0]  target,
  output logic      [`CBU_PC_W-1:0]  next_seq
);

  // offset widened with its sign bit
  wire [`CBU_PC_W-1:0] ofs_sx = {{(`CBU_PC_W-`CBU_OFS_W){ofs[`CBU_OFS_W-1]}}, ofs};
  // one, at counter width
  wire [`CBU_PC_W-1:0] one_w  = {{(`CBU_PC_W-1){1'b0}}, 1'b1};

  assign target   = pc + ofs_sx + one_w;
  assign next_seq = pc + one_w;

endmodule

// file: rtl/cbu_top.sv
// conditional branch unit: apb register file, sequencer, pc and flag holding
// assumes one apb master on core_clk; reset is synchronous and active high
// every apb access sees exactly one wait state; reads are captured in it
// the core side sees pc, flags and one-cycle pulses, all registered
`timescale 1ns/10ps
`include "cbu_params.svh"

module cbu_top
(
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   sys_rst,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`CBU_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic      [31:0]            prdata,
  output logic                        pslverr,
  // core side view
  output logic      [`CBU_PC_W-1:0]   pc_out,
  output logic      [`CBU_FLG_W-1:0]  flags_out,
  output logic                        busy,
  output logic                        branch_taken,
  output logic                        step_done
);
  // package types: condition codes and sequencer states
  import cbu_pkg::*;

  // address match helper, used by every decode
  // a plain compare: registers are whole aligned words, no byte lanes
  function automatic logic reg_hit(input logic [`CBU_ADDR_W-1:0] a,
                                   input logic [`CBU_ADDR_W-1:0] off);
    reg_hit = (a == off);
  endfunction

  // sequencer state
  cbu_state_t              state_q;     // current state
  cbu_state_t              state_d;     // next state
  // architectural state
  logic [`CBU_PC_W-1:0]    pc_q;        // program counter
  logic [`CBU_PC_W-1:0]    pc_d;
  logic [`CBU_FLG_W-1:0]   flags_q;     // status flags, software owned
  logic [`CBU_FLG_W-1:0]   flags_d;
  // instruction latch
  // held from launch so the evaluation never sees a later bus write
  logic [`CBU_COND_W-1:0]  cond_q;      // condition code
  logic [`CBU_OFS_W-1:0]   ofs_q;       // signed offset
  // status
  // busy, taken, done and cycle count form the status word
  logic                    busy_q;      // branch in flight
  logic                    taken_q;     // last branch was taken
  logic                    done_q;      // sticky completion flag
  logic [1:0]              cyc_q;       // cycles of the last branch
  logic                    taken_p_q;   // one-cycle taken pulse
  logic                    done_p_q;    // one-cycle done pulse
  // apb answer
  // these stand for the completing cycle only
  logic                    pready_q;
  logic [31:0]             prdata_q;
  logic                    pslverr_q;

  // evaluator and adder results
  // both come from combinational submodules
  logic                    cond_true;
  logic [`CBU_PC_W-1:0]    target;
  logic [`CBU_PC_W-1:0]    next_seq;

  // state decode
  // one-hot, so each compare needs a single bit
  wire st_idle = (state_q == CBU_ST_IDLE);
  wire st_eval = (state_q == CBU_ST_EVAL);
  wire st_jump = (state_q == CBU_ST_JUMP);

  // address decode
  // only the four word offsets answer; any other address is an error
  wire hit_instr  = reg_hit(paddr, `CBU_OFF_INSTR);
  wire hit_pc     = reg_hit(paddr, `CBU_OFF_PC);
  wire hit_flags  = reg_hit(paddr, `CBU_OFF_FLAGS);
  wire hit_status = reg_hit(paddr, `CBU_OFF_STATUS);
  wire hit_any    = hit_instr | hit_pc | hit_flags | hit_status;

  // apb phases: wait is the first access cycle, fin the completing edge
  // pready_q doubles as the phase marker: low in the first access cycle,
  // high in the second, so no separate phase register is needed
  wire apb_wait = psel & penable & ~pready_q;
  wire apb_fin  = psel & penable & pready_q;
  // a write lands only at the completing edge, and only without an error
  wire wr_ok    = apb_fin & pwrite & ~pslverr_q;

  // instruction, pc and flag writes are refused while a branch is in flight
  // a pc or flag write mid-branch would corrupt the target or the test
  wire wr_locked = pwrite & ~st_idle & (hit_instr | hit_pc | hit_flags);
  // unmapped reads are refused as well, with zero data
  wire acc_err   = ~hit_any | wr_locked;

  // individual write strobes
  wire wr_instr  = wr_ok & hit_instr;
  wire wr_pc     = wr_ok & hit_pc;
  wire wr_flags  = wr_ok & hit_flags;
  wire wr_status = wr_ok & hit_status;

  // done flag clear: write one to its bit in status
  // the clear only acts on a completing, error-free status write
  wire done_clr = wr_status & pwdata[`CBU_ST_DONE];
  // branch finishes in eval when not taken, in jump when taken
  wire fin_fall  = st_eval & ~cond_true;
  wire fin_taken = st_jump;
  // fin_any marks the last cycle of every branch, taken or not
  wire fin_any   = fin_fall | fin_taken;

  // read-back words
  // unused bits read as zero so software may compare whole words
  wire [31:0] rd_instr  = {{(32-`CBU_INS_OFS_HI-1){1'b0}}, ofs_q, cond_q};
  wire [31:0] rd_pc     = {{(32-`CBU_PC_W){1'b0}}, pc_q};
  wire [31:0] rd_flags  = {{(32-`CBU_FLG_W){1'b0}}, flags_q};
  wire [31:0] rd_status = {{(32-`CBU_ST_CYC_HI-1){1'b0}}, cyc_q, 1'b0,
                           done_q, taken_q, busy_q};
  // read mux, zero for unmapped addresses
  wire [31:0] rd_mux = hit_instr  ? rd_instr  :
                       hit_pc     ? rd_pc     :
                       hit_flags  ? rd_flags  :
                       hit_status ? rd_status : 32'h0000_0000;

  // condition test on the latched code and current flags
  // the cast is safe: every four-bit code names a condition
  cbu_cond_eval u_cond
  (
    .cond      (cbu_cond_t'(cond_q)),
    .flags     (flags_q),
    .cond_true (cond_true)
  );

  // target and sequential addresses
  // both sums are formed every cycle; the finish picks one
  cbu_target_add u_add
  (
    .pc       (pc_q),
    .ofs      (ofs_q),
    .target   (target),
    .next_seq (next_seq)
  );

  // next state: launch, evaluate, optional second cycle
  // idle waits for a launch; eval is the first cycle of every branch
  // jump is the extra cycle that a taken branch costs
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      CBU_ST_IDLE:
      begin
        // instruction write starts a branch
        if (wr_instr)
          state_d = CBU_ST_EVAL;
      end
      CBU_ST_EVAL:
      begin
        // taken branches spend a second cycle
        if (cond_true)
          state_d = CBU_ST_JUMP;
        else
          state_d = CBU_ST_IDLE;
      end
      // second cycle of a taken branch, always back to idle
      CBU_ST_JUMP:
        state_d = CBU_ST_IDLE;
      // unreachable codes fall back to idle
      default:
        state_d = CBU_ST_IDLE;
    endcase
  end

  // next pc: software load, fall through or jump
  // a load and a finish never meet: pc writes are refused while busy
  // targets wrap modulo the counter width
  always_comb
  begin
    pc_d = pc_q;
    if (wr_pc)
      pc_d = pwdata[`CBU_PC_W-1:0];
    else if (fin_fall)
      pc_d = next_seq;
    else if (fin_taken)
      pc_d = target;
  end

  // next flags: only software writes them, branches never do
  // here the flags are only an input to the condition test
  always_comb
  begin
    flags_d = flags_q;
    if (wr_flags)
      flags_d = pwdata[`CBU_FLG_W-1:0];
  end

  // sequencer register
  // synchronous reset returns to idle; no branch survives a reset
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      state_q <= CBU_ST_IDLE;
    else
      state_q <= state_d;
  end

  // pc and flags registers
  // reset values come from the constants header
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      pc_q    <= `CBU_RST_PC;
      flags_q <= `CBU_RST_FLAGS;
    end
    else
    begin
      pc_q    <= pc_d;
      flags_q <= flags_d;
    end
  end

  // instruction latch, loaded only on launch
  // a refused instruction write leaves the previous code in place
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      cond_q <= {`CBU_COND_W{1'b0}};
      ofs_q  <= {`CBU_OFS_W{1'b0}};
    end
    else if (wr_instr)
    begin
      cond_q <= pwdata[`CBU_INS_COND_HI:`CBU_INS_COND_LO];
      ofs_q  <= pwdata[`CBU_INS_OFS_HI:`CBU_INS_OFS_LO];
    end
  end

  // busy follows launch and finish
  // launch and finish cannot meet, since launches are refused while busy
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      busy_q <= 1'b0;
    else if (wr_instr)
      busy_q <= 1'b1;
    else if (fin_any)
      busy_q <= 1'b0;
  end

  // outcome and cycle count of the last branch
  // these stay readable until the next branch overwrites them
  // the cycle count is what software reads to see the branch cost
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      taken_q <= 1'b0;
      cyc_q   <= 2'h0;
    end
    else if (fin_fall)
    begin
      taken_q <= 1'b0;
      cyc_q   <= `CBU_CYC_FALL;
    end
    else if (fin_taken)
    begin
      taken_q <= 1'b1;
      cyc_q   <= `CBU_CYC_TAKEN;
    end
  end

  // sticky done: a finish in the clearing cycle wins
  // software clears it by writing one to its bit
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      done_q <= 1'b0;
    else if (fin_any)
      done_q <= 1'b1;
    else if (done_clr)
      done_q <= 1'b0;
  end

  // one-cycle pulses toward the core
  // delayed one cycle so they line up with the pc already loaded
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      taken_p_q <= 1'b0;
      done_p_q  <= 1'b0;
    end
    else
    begin
      taken_p_q <= fin_taken;
      done_p_q  <= fin_any;
    end
  end

  // apb ready: one wait cycle, then high for the completing edge
  // never high two cycles running, so back-to-back accesses stay apart
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      pready_q <= 1'b0;
    else if (apb_wait)
      pready_q <= 1'b1;
    else
      pready_q <= 1'b0;
  end

  // apb read data and error, captured in the wait cycle
  // writes return zero data; the completing edge clears data and error
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else if (apb_wait)
    begin
      prdata_q  <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_q <= acc_err;
    end
    else if (apb_fin)
    begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
  end

  // outputs, all from flip-flops
  // plain wires from registers, nothing combinational reaches a port
  assign pready       = pready_q;
  assign prdata       = prdata_q;
  assign pslverr      = pslverr_q;
  assign pc_out       = pc_q;
  assign flags_out    = flags_q;
  assign busy         = busy_q;
  assign branch_taken = taken_p_q;
  assign step_done    = done_p_q;

endmodule

// file: tb/cbu_sva.sv
// checker of the branch unit: latency, pc update, flag holding, conditions
// assumes a bind to cbu_top; one clock, synchronous active-high reset
`timescale 1ns/10ps
`include "cbu_params.svh"

module cbu_sva
(
  // clock and reset
  input wire logic                   core_clk,
  input wire logic                   sys_rst,
  // apb slave
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [`CBU_ADDR_W-1:0] paddr,
  input wire logic [31:0]            pwdata,
  input wire logic                   pready,
  input wire logic [31:0]            prdata,
  input wire logic                   pslverr,
  // core side view
  input wire logic [`CBU_PC_W-1:0]   pc_out,
  input wire logic [`CBU_FLG_W-1:0]  flags_out,
  input wire logic                   busy,
  input wire logic                   branch_taken,
  input wire logic                   step_done
);
  logic                 launch;  // accepted instruction write
  logic [3:0]           cond_q;  // condition of the last launch
  logic [`CBU_PC_W-1:0] tgt_q;   // target expected if taken
  logic [7:0]           f;       // short name for the flags
  assign f = flags_out;
  assign launch = psel && penable && pready && pwrite && !pslverr && (paddr == `CBU_OFF_INSTR);
  // capture condition and target as the branch launches
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      cond_q <= 4'h0;
      tgt_q  <= 12'h000;
    end
    else if (launch)
    begin
      cond_q <= pwdata[3:0];
      tgt_q  <= pc_out + {{5{pwdata[10]}}, pwdata[10:4]} + 12'h001;
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  AST_FLAGS_HOLD: assert property (busy |-> $stable(flags_out))
    else $error("flags moved during a branch");
  AST_LATENCY: assert property ($rose(busy) |-> (##1 (!busy && step_done && !branch_taken))
    or (##1 busy ##1 (!busy && step_done && branch_taken))) else $error("branch cycle count wrong");
  AST_PC_FALL: assert property (step_done && !branch_taken |-> pc_out == $past(pc_out) + 12'h001)
    else $error("fall-through pc wrong");
  AST_PC_TAKEN: assert property (branch_taken |-> pc_out == tgt_q)
    else $error("taken pc wrong");
  AST_CARRY: assert property (step_done && cond_q[3:1] == 3'h0 |-> branch_taken == (f[0] == cond_q[0]))
    else $error("carry branch wrong");
  AST_ALIAS: assert property (step_done && cond_q[3:1] == 3'h1 |-> branch_taken == (f[0] == cond_q[0]))
    else $error("unsigned branch wrong");
  AST_NEG: assert property (step_done && cond_q[3:1] == 3'h2 |-> branch_taken == (f[2] != cond_q[0]))
    else $error("sign branch wrong");
  AST_GE: assert property (step_done && cond_q == 4'h6 |-> branch_taken == !(f[2] ^ f[3]))
    else $error("signed ge wrong");
  AST_LT: assert property (step_done && cond_q == 4'h7 |-> branch_taken == (f[2] ^ f[3]))
    else $error("signed lt wrong");
  AST_HALF: assert property (step_done && cond_q[3:1] == 3'h4 |-> branch_taken == (f[5] != cond_q[0]))
    else $error("half carry branch wrong");
  AST_TRANS: assert property (step_done && cond_q[3:1] == 3'h5 |-> branch_taken == (f[6] != cond_q[0]))
    else $error("transfer branch wrong");
  AST_OVF: assert property (step_done && cond_q[3:1] == 3'h6 |-> branch_taken == (f[3] != cond_q[0]))
    else $error("overflow branch wrong");
  AST_IRQ: assert property (step_done && cond_q[3:1] == 3'h7 |-> branch_taken == (f[7] != cond_q[0]))
    else $error("irq branch wrong");
  // main scenarios reached
  COV_TAKEN: cover property (branch_taken);
  COV_FALL: cover property (step_done && !branch_taken);
  COV_ERR: cover property (pready && pslverr);
endmodule

// file: tb/conditional_branch_unit_tb.sv
// bench of the branch unit: random branches against an integer model
// assumes the checker file is compiled first; apb master drives at rising edges
`timescale 1ns/10ps
`include "cbu_params.svh"

module conditional_branch_unit_tb;
  logic        core_clk = 1'b0;   // bench clock, 100 ns
  logic        sys_rst = 1'b1;    // held through the first cycles
  logic        psel = 1'b0;       // apb select
  logic        penable = 1'b0;    // apb enable
  logic        pwrite = 1'b0;     // apb direction
  logic [11:0] paddr = 12'h000;   // apb address
  logic [31:0] pwdata = 32'h0;    // apb write data
  logic        pready;            // apb answer
  logic        pslverr;           // apb error
  logic [31:0] prdata;            // apb read data
  logic [11:0] pc_out;            // pc view
  logic [7:0]  flags_out;         // flag view
  logic        busy;              // branch running
  logic        branch_taken;      // taken pulse
  logic        step_done;         // finished pulse
  logic [31:0] rd;                // last read data
  logic        err;               // last error
  int          num_errors = 0;    // mismatches
  int          tests_run = 0;     // comparisons
  int          pc;                // model pc
  int          fl;                // model flags
  int          ofs;               // offset field
  int          tk;                // model taken
  int          exp_q[$];          // expected pcs, oldest first
  cbu_top dut (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .pc_out(pc_out), .flags_out(flags_out), .busy(busy),
    .branch_taken(branch_taken), .step_done(step_done));
  // free-running clock
  always #50 core_clk = ~core_clk;
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic stop_test;
    $display("errors %0d of %0d compares", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // one apb transfer, held until pready at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      num_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // reference condition test from the flag integers
  function automatic int taken(int c, int f);
    int b;
    b = c & 1;
    case (c >> 1)
      0, 1: return ((f & 1) == b);
      2: return (((f >> 2) & 1) != b);
      3: return ((((f >> 2) ^ (f >> 3)) & 1) == b);
      4: return (((f >> 5) & 1) != b);
      5: return (((f >> 6) & 1) != b);
      6: return (((f >> 3) & 1) != b);
      default: return (((f >> 7) & 1) != b);
    endcase
  endfunction
  // main sequence
  initial
  begin
    pc = $urandom(32'h678ce22a);
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    apb(1'b0, `CBU_OFF_PC, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
    // every condition code four times, random flags, pc and offset
    for (int i = 0; i < 64; i++)
    begin
      fl = $urandom & 255;
      pc = $urandom & 4095;
      ofs = $urandom & 127;
      apb(1'b1, `CBU_OFF_FLAGS, fl);
      apb(1'b1, `CBU_OFF_PC, pc);
      apb(1'b1, `CBU_OFF_INSTR, (ofs << 4) | (i % 16));
      tk = taken(i % 16, fl);
      pc = tk ? (pc + ofs - ((ofs & 64) << 1) + 1) & 4095 : (pc + 1) & 4095;
      exp_q.push_back(pc);
      for (int w = 0; w < 8 && step_done !== 1'b1; w++) @(posedge core_clk);
      check(step_done, 1);
      check(branch_taken, tk);
      apb(1'b0, `CBU_OFF_PC, 32'h0);
      check(rd, exp_q.pop_front());
      apb(1'b0, `CBU_OFF_FLAGS, 32'h0);
      check(rd, fl);
      apb(1'b0, `CBU_OFF_STATUS, 32'h0);
      check(rd, ((tk + 1) << 4) | 4 | (tk << 1));
      check(err, 1'b0);
    end
    // clearing done by writing one leaves outcome and cycle count
    apb(1'b1, `CBU_OFF_STATUS, 32'h4);
    apb(1'b0, `CBU_OFF_STATUS, 32'h0);
    check(rd, ((tk + 1) << 4) | (tk << 1));
    stop_test();
  end
  // cut a hang short
  initial
  begin
    #2000000;
    num_errors++;
    stop_test();
  end
endmodule

bind cbu_top cbu_sva chk (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .pc_out(pc_out), .flags_out(flags_out), .busy(busy),
  .branch_taken(branch_taken), .step_done(step_done));
